// >>> logic/stdt_timer.sv
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Contract
// - Five modes: compare, counter, capture, pulse, PWM; code has four (compare, capture, PWM, timer), single pulse is a PWM function
// - Ext clock pin, capture pin, one output
// - Up-only counter, 10 or 16 bits
// - Period value checks counter top bits only
// - Full compare value checks all bits
// - Software only clears counter via on rise
// - Overflow or match clears counter, raises request
// - Count read-only pair; compare read/write pair
// - Period in own register or control A
// - Pause bit holds counter, resumes later
// - Clock select picks one of eight sources; codes 4 and 5 both pick the low clock
// - On bit off stops; rise clears counter
// - On rise restores output initial level
// - Small period N gives N*128 clocks
// - Period match clears only if select zero; capture mode always clears on it, PWM uses the swap bit instead
// - Period zero lets counter overflow fully
// - Mode field chooses operating mode
// - Clear select: period/overflow or compare
// - Low bytes go through an 8-bit buffer
// - Compare match drives output per function
module stdt_timer
  import stdt_pkg::*;
#(
  parameter int CNT_W = 16,  // Counter width, 10 or 16
  parameter int PER_W = 8    // Period width, 3 or 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer pins, routed by the pin mux outside
  input  wire logic        extClkPin,
  input  wire logic        capturePin,
  output logic             timerOutPin,
  // Internal clock sources, asynchronous
  input  wire logic        highClkSrc,
  input  wire logic        lowClkSrc,
  // Event requests
  output logic             cmpMatchIrq,
  output logic             periodIrq
);

  // Derived sizes
  localparam int  HI_W     = CNT_W - 8;
  localparam bit  PER_IN_A = (PER_W == 3);  // Small instance layout
  localparam int  ZPAD     = CNT_W - PER_W;

  // Registers
  logic [7:0]       ctrlA_reg;     // Pause, clock, on, small period
  logic [7:0]       ctrlB_reg;     // Mode, function, level, clear
  logic [PER_W-1:0] period_reg;    // Large instance period
  logic [CNT_W-1:0] cmp_reg;       // Full compare value
  logic [7:0]       cmpBuf_reg;    // Compare low byte buffer
  logic [7:0]       cntBuf_reg;    // Count low byte buffer
  logic [CNT_W-1:0] cnt_reg;       // Core counter
  logic [CNT_W-1:0] cnt_next;
  logic             onPrev_reg;    // On bit last cycle
  logic [3:0]       sync1_reg;     // First synchroniser stage
  logic [3:0]       sync2_reg;     // Second synchroniser stage
  logic [3:0]       sync3_reg;     // Edge history
  logic [1:0]       sysDiv_reg;    // System clock divider
  logic [5:0]       hiDiv_reg;     // High clock edge divider
  logic             outLvl_reg;    // Compare-mode output level
  logic             outLvl_next;
  logic             pulseOn_reg;   // Single pulse active
  logic             pin_reg;       // Registered output pin
  logic             pin_next;
  logic             aIrq_reg;
  logic             pIrq_reg;
  logic [31:0]      prdata_reg;

  // Control fields
  wire              pauseBit  = ctrlA_reg[CA_PAUSE];
  wire [2:0]        clkSel    = ctrlA_reg[CA_CLK_HI:CA_CLK_LO];
  wire              onBit     = ctrlA_reg[CA_ON];
  wire [1:0]        fnField   = ctrlB_reg[CB_FN_HI:CB_FN_LO];
  wire              initLvl   = ctrlB_reg[CB_OC];
  wire              polBit    = ctrlB_reg[CB_POL];
  wire              dpxBit    = ctrlB_reg[CB_DPX];
  wire              clrSel    = ctrlB_reg[CB_CCLR];
  stdt_mode_t       mode;
  assign mode = stdt_mode_t'(ctrlB_reg[CB_MODE_HI:CB_MODE_LO]);

  // Period value source differs per instance
  wire [PER_W-1:0]  perVal = PER_IN_A ? ctrlA_reg[PER_W-1:0] : period_reg;

  // On bit rising edge
  wire              onRise = onBit & ~onPrev_reg;

  // APB decode
  wire              access  = psel & penable;
  wire              wrEn    = access & pwrite;
  wire              rdEn    = access & ~pwrite;
  wire              rdSet   = psel & ~penable & ~pwrite;  // Read setup cycle
  wire              hitCa   = (paddr == OFS_CTRL_A);
  wire              hitCb   = (paddr == OFS_CTRL_B);
  wire              hitCntL = (paddr == OFS_CNT_LO);
  wire              hitCntH = (paddr == OFS_CNT_HI);
  wire              hitCmpL = (paddr == OFS_CMP_LO);
  wire              hitCmpH = (paddr == OFS_CMP_HI);
  wire              hitPer  = (paddr == OFS_PERIOD) & ~PER_IN_A;
  wire              hitAny  = hitCa | hitCb | hitCntL | hitCntH
                            | hitCmpL | hitCmpH | hitPer;

  // Large instance has no period bits in control A
  wire [7:0]        caMask  = PER_IN_A ? 8'hFF : 8'hF8;

  // Read data selection
  wire [31:0]       rdMux =
      hitCa   ? {24'h0000_00, ctrlA_reg & caMask} :
      hitCb   ? {24'h0000_00, ctrlB_reg} :
      hitCntL ? {24'h0000_00, cntBuf_reg} :
      hitCntH ? {{(40-CNT_W){1'b0}}, cnt_reg[CNT_W-1:8]} :
      hitCmpL ? {24'h0000_00, cmpBuf_reg} :
      hitCmpH ? {{(40-CNT_W){1'b0}}, cmp_reg[CNT_W-1:8]} :
      hitPer  ? {{(32-PER_W){1'b0}}, period_reg} :
                32'h0000_0000;

  // Synchronised pin events; only stage two and three are read
  wire              extRise = sync2_reg[0] & ~sync3_reg[0];
  wire              extFall = ~sync2_reg[0] & sync3_reg[0];
  wire              hiRise  = sync2_reg[1] & ~sync3_reg[1];
  wire              lowRise = sync2_reg[2] & ~sync3_reg[2];
  wire              capRise = sync2_reg[3] & ~sync3_reg[3];
  wire              capFall = ~sync2_reg[3] & sync3_reg[3];

  // Divided clock ticks
  wire              sys4Tick = (sysDiv_reg == DIV4_LAST);
  wire              hi16Tick = hiRise & (hiDiv_reg[3:0] == DIV16_LAST);
  wire              hi64Tick = hiRise & (hiDiv_reg == DIV64_LAST);

  // Counter clock selection
  logic srcTick;
  always_comb begin
    case (clkSel)
      CLK_SYS_4:    srcTick = sys4Tick;
      CLK_SYS:      srcTick = 1'b1;
      CLK_HI_16:    srcTick = hi16Tick;
      CLK_HI_64:    srcTick = hi64Tick;
      CLK_LOW_A:    srcTick = lowRise;
      CLK_LOW_B:    srcTick = lowRise;
      CLK_EXT_RISE: srcTick = extRise;
      CLK_EXT_FALL: srcTick = extFall;
      default:      srcTick = 1'b0;
    endcase
  end

  // Counter advances only while on and not paused
  wire              tick = srcTick & onBit & ~pauseBit;

  // Next count with carry for overflow
  wire [CNT_W:0]    cntInc = {1'b0, cnt_reg} + {{CNT_W{1'b0}}, 1'b1};

  // Period compare on top bits; zero period means overflow
  wire [CNT_W-1:0]  perFull = {perVal, {ZPAD{1'b0}}};
  wire              perHit  = (perVal != '0)
                            ? (cntInc[CNT_W-1:0] == perFull)
                            : cntInc[CNT_W];
  wire              pMatch  = tick & perHit;

  // Full compare on all bits
  wire              aMatch  = tick & (cntInc[CNT_W-1:0] == cmp_reg);

  // Clearing source
  wire              clrEv =
      (mode == MODE_PWM) ? (dpxBit ? aMatch : pMatch) :
      (mode == MODE_CAP) ? pMatch :
      (clrSel ? aMatch : pMatch);

  // Capture events on the capture pin
  logic capEdge;
  always_comb begin
    case (fnField)
      FN_0:    capEdge = capRise;
      FN_1:    capEdge = capFall;
      FN_2:    capEdge = capRise | capFall;
      default: capEdge = 1'b0;  // Capture disabled
    endcase
  end
  wire              capEv = capEdge & onBit & (mode == MODE_CAP);

  // Counter next value; no software load path exists
  always_comb begin
    if (onRise) begin
      cnt_next = '0;
    end else if (tick) begin
      cnt_next = clrEv ? '0 : cntInc[CNT_W-1:0];
    end else begin
      cnt_next = cnt_reg;  // Held when off or paused
    end
  end

  // PWM duty source chosen by duty/period swap bit
  wire [CNT_W-1:0]  duty = dpxBit ? perFull : cmp_reg;
  logic pwmActive;
  always_comb begin
    case (fnField)
      FN_0:    pwmActive = 1'b0;
      FN_1:    pwmActive = 1'b1;
      FN_2:    pwmActive = (cnt_reg < duty);
      default: pwmActive = pulseOn_reg;  // Single pulse
    endcase
  end
  wire              pwmLvl = pwmActive ? initLvl : ~initLvl;

  // Compare-mode output level
  always_comb begin
    outLvl_next = outLvl_reg;
    if (onRise) begin
      outLvl_next = initLvl;
    end else if (aMatch && mode == MODE_CMP) begin
      case (fnField)
        FN_1:    outLvl_next = 1'b0;
        FN_2:    outLvl_next = 1'b1;
        FN_3:    outLvl_next = ~outLvl_reg;
        default: outLvl_next = outLvl_reg;
      endcase
    end
  end

  // Pin level; timer mode drives low since its level is unused
  always_comb begin
    case (mode)
      MODE_TMR: pin_next = 1'b0;
      MODE_PWM: pin_next = pwmLvl ^ polBit;
      default:  pin_next = outLvl_next ^ polBit;
    endcase
  end

  // Pin synchronisers, two stages plus edge history
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end else begin
      sync1_reg <= {capturePin, lowClkSrc, highClkSrc, extClkPin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Prescalers idle while off to save power
  always_ff @(posedge clk) begin
    if (!nrst || !onBit) begin
      sysDiv_reg <= 2'h0;
      hiDiv_reg  <= 6'h00;
    end else begin
      sysDiv_reg <= sysDiv_reg + 2'h1;
      if (hiRise) begin
        hiDiv_reg <= hiDiv_reg + 6'h01;
      end
    end
  end

  // Counter and on-edge history
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_reg    <= '0;
      onPrev_reg <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      onPrev_reg <= onBit;
    end
  end

  // Output state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      outLvl_reg  <= 1'b0;
      pulseOn_reg <= 1'b0;
      pin_reg     <= 1'b0;
    end else begin
      outLvl_reg <= outLvl_next;
      pin_reg    <= pin_next;
      if (onRise) begin
        pulseOn_reg <= 1'b1;  // Pulse starts with the on edge
      end else if (aMatch) begin
        pulseOn_reg <= 1'b0;
      end
    end
  end

  // Match requests, one cycle each and kept apart
  always_ff @(posedge clk) begin
    if (!nrst) begin
      aIrq_reg <= 1'b0;
      pIrq_reg <= 1'b0;
    end else begin
      aIrq_reg <= (mode == MODE_CAP) ? capEv : aMatch;
      pIrq_reg <= pMatch;
    end
  end

  // Control registers written by software
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrlA_reg  <= CTRL_A_RST;
      ctrlB_reg  <= CTRL_B_RST;
      period_reg <= '0;
    end else if (wrEn) begin
      if (hitCa) begin
        ctrlA_reg <= pwdata[7:0] & caMask;
      end
      if (hitCb) begin
        ctrlB_reg <= pwdata[7:0];
      end
      if (hitPer) begin
        period_reg <= pwdata[PER_W-1:0];
      end
    end
  end

  // Compare value and its low-byte buffer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmp_reg    <= '0;
      cmpBuf_reg <= 8'h00;
    end else begin
      if (wrEn && hitCmpL) begin
        cmpBuf_reg <= pwdata[7:0];  // Buffer only
      end else if (rdSet && hitCmpH) begin
        cmpBuf_reg <= cmp_reg[7:0];  // Same edge as the high byte
      end
      // Software write beats a capture in the same cycle
      if (wrEn && hitCmpH) begin
        cmp_reg <= {pwdata[HI_W-1:0], cmpBuf_reg};
      end else if (capEv) begin
        cmp_reg <= cnt_reg;
      end
    end
  end

  // Low byte taken at the edge the high byte is, so a carry cannot tear the pair
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cntBuf_reg <= 8'h00;
    end else if (rdSet && hitCntH) begin
      cntBuf_reg <= cnt_reg[7:0];
    end
  end

  // Read data prepared during the setup phase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rdSet) begin
      prdata_reg <= rdMux;
    end
  end

  // Zero wait states; unmapped offsets answer with an error
  assign pready      = 1'b1;
  assign pslverr     = access & ~hitAny;
  assign prdata      = prdata_reg;
  assign timerOutPin = pin_reg;
  assign cmpMatchIrq = aIrq_reg;
  assign periodIrq   = pIrq_reg;

endmodule

// >>> logic/stdt_pkg.sv
package stdt_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] OFS_CTRL_A   = 8'h00;
  localparam logic [7:0] OFS_CTRL_B   = 8'h04;
  localparam logic [7:0] OFS_CNT_LO   = 8'h08;
  localparam logic [7:0] OFS_CNT_HI   = 8'h0C;
  localparam logic [7:0] OFS_CMP_LO   = 8'h10;
  localparam logic [7:0] OFS_CMP_HI   = 8'h14;
  localparam logic [7:0] OFS_PERIOD   = 8'h18;
  // Reset values
  localparam logic [7:0] CTRL_A_RST   = 8'h00;
  localparam logic [7:0] CTRL_B_RST   = 8'h00;
  // Control A field positions
  localparam int         CA_PAUSE     = 7;
  localparam int         CA_CLK_HI    = 6;
  localparam int         CA_CLK_LO    = 4;
  localparam int         CA_ON        = 3;
  // Control B field positions
  localparam int         CB_MODE_HI   = 7;
  localparam int         CB_MODE_LO   = 6;
  localparam int         CB_FN_HI     = 5;
  localparam int         CB_FN_LO     = 4;
  localparam int         CB_OC        = 3;
  localparam int         CB_POL       = 2;
  localparam int         CB_DPX       = 1;
  localparam int         CB_CCLR      = 0;
  // Counter clock select codes
  localparam logic [2:0] CLK_SYS_4    = 3'h0;
  localparam logic [2:0] CLK_SYS      = 3'h1;
  localparam logic [2:0] CLK_HI_16    = 3'h2;
  localparam logic [2:0] CLK_HI_64    = 3'h3;
  localparam logic [2:0] CLK_LOW_A    = 3'h4;
  localparam logic [2:0] CLK_LOW_B    = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;
  // Divider terminal counts
  localparam logic [1:0] DIV4_LAST    = 2'h3;
  localparam logic [3:0] DIV16_LAST   = 4'hF;
  localparam logic [5:0] DIV64_LAST   = 6'h3F;
  // Pin function codes
  localparam logic [1:0] FN_0         = 2'h0;
  localparam logic [1:0] FN_1         = 2'h1;
  localparam logic [1:0] FN_2         = 2'h2;
  localparam logic [1:0] FN_3         = 2'h3;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_CMP = 2'h0,
    MODE_CAP = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TMR = 2'h3
  } stdt_mode_t;
endpackage

// >>> sim/stdt_timer_properties.sv
`timescale 1ns/100ps
module stdt_timer_properties
  import stdt_pkg::*;
#(
  parameter int PER_W = 8  // Period width, sets the unmapped range
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // APB slave
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin and requests
  input wire logic        timerOutPin,
  input wire logic        cmpMatchIrq,
  input wire logic        periodIrq
);
  // Period register exists only on the wide instance
  wire logic [7:0] lastAddr = (PER_W == 3) ? OFS_CMP_HI : OFS_PERIOD;
  wire logic       accPhase = psel && penable;
  wire logic       badAddr  = (paddr > lastAddr) || (paddr[1:0] != 2'h0);
  wire logic       rdSetup  = psel && !penable && !pwrite;
  logic            onReg;     // Shadow of the on bit
  logic            pauseReg;  // Shadow of the pause bit
  wire logic       stopped  = !onReg || pauseReg;

  // Shadow follows control A writes only; others never touch it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      onReg    <= 1'b0;
      pauseReg <= 1'b0;
    end else if (accPhase && pwrite && paddr == OFS_CTRL_A) begin
      onReg    <= pwdata[CA_ON];
      pauseReg <= pwdata[CA_PAUSE];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_ready_now;
    accPhase |-> pready;
  endproperty
  a_ready_now: assert property (p_ready_now) else $error("no ready in access");
  property p_err_map;
    pslverr == (accPhase && badAddr);
  endproperty
  a_err_map: assert property (p_err_map) else $error("error flag wrong");
  property p_err_data;
    accPhase && !pwrite && badAddr |-> prdata == 32'h0000_0000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("unmapped read data");
  property p_rdata_hold;
    !rdSetup |=> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_reset_quiet;
    disable iff (1'b0) !nrst |=> !cmpMatchIrq && !periodIrq && !timerOutPin;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs after reset");
  property p_cmp_pulse;
    cmpMatchIrq |=> !cmpMatchIrq;
  endproperty
  a_cmp_pulse: assert property (p_cmp_pulse) else $error("compare request long");
  property p_per_space;
    periodIrq |=> (!periodIrq) [*8];
  endproperty
  a_per_space: assert property (p_per_space) else $error("period requests close");
  property p_quiet_stop;
    stopped && $past(stopped) && $past(stopped, 2) |-> !periodIrq && (onReg || !cmpMatchIrq);
  endproperty
  a_quiet_stop: assert property (p_quiet_stop) else $error("request while stopped");
endmodule

bind stdt_timer stdt_timer_properties #(.PER_W(PER_W)) u_props (
  .clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .timerOutPin, .cmpMatchIrq, .periodIrq
);

// >>> sim/standard_timer_module_bench.sv
`timescale 1ns/100ps
module standard_timer_module_bench;
  import stdt_pkg::*;
  // Bench drive
  logic        clk, nrst, psel, penable, pwrite, extClkPin, capturePin;
  logic        highClkSrc, lowClkSrc;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  // Design outputs
  logic [31:0] prdata;
  logic        pready, pslverr, timerOutPin, cmpMatchIrq, periodIrq;
  // Bookkeeping
  int          num_errors, checks_done, tk;
  logic [31:0] rdat;
  logic        serr;

  // Small instance: period lives in control A
  // Pins reach the block directly, as if the pin mux were already set
  stdt_timer #(.CNT_W(10), .PER_W(3)) DUT (
    .clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .extClkPin, .capturePin, .timerOutPin, .highClkSrc, .lowClkSrc,
    .cmpMatchIrq, .periodIrq
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Free sources: high period 4 clocks, low period 16 clocks
  always @(posedge clk) begin
    tk <= tk + 1;
    highClkSrc <= tk[1];
    lowClkSrc <= tk[3];
  end

  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds everything until ready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask
  // High byte first so the low byte is latched with it
  task automatic rd_pair(input logic [7:0] hiA, output logic [15:0] v);
    apb(1'b0, hiA, 32'h0000_0000);
    v[15:8] = rdat[7:0];
    apb(1'b0, hiA - 8'h04, 32'h0000_0000);
    v[7:0] = rdat[7:0];
  endtask
  task automatic setcmp(input logic [15:0] v);
    apb(1'b1, OFS_CMP_LO, {24'h00_0000, v[7:0]});
    apb(1'b1, OFS_CMP_HI, {24'h00_0000, v[15:8]});
  endtask
  // Off first, so the on write is a rise that clears the counter
  task automatic start(input logic [7:0] ca, input logic [7:0] cb);
    apb(1'b1, OFS_CTRL_A, 32'h0000_0000);
    apb(1'b1, OFS_CTRL_B, {24'h00_0000, cb});
    apb(1'b1, OFS_CTRL_A, {24'h00_0000, ca});
  endtask
  task automatic pulse(input logic per, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((per ? periodIrq : cmpMatchIrq) !== 1'b1 && n < lim);
  endtask
  // Cycles between two requests of one kind
  task automatic gap(input logic per, input int exp);
    int n;
    pulse(per, 40000, n);
    if (n >= 40000) begin
      num_errors++;
      wrap_up();
    end
    pulse(per, exp + 16, n);
    chk(n, exp);
  endtask

  task automatic t_regs();
    rdchk(OFS_CTRL_A, CTRL_A_RST);
    rdchk(OFS_CTRL_B, CTRL_B_RST);
    apb(1'b1, OFS_CNT_LO, 32'h0000_00AA);
    rdchk(OFS_CNT_HI, 32'h0000_0000);
    rdchk(OFS_CNT_LO, 32'h0000_0000);
    setcmp(16'h0234);
    apb(1'b1, OFS_CMP_LO, 32'h0000_0055);
    rdchk(OFS_CMP_HI, 32'h0000_0002);
    rdchk(OFS_CMP_LO, 32'h0000_0034);
    apb(1'b1, OFS_CTRL_A, 32'h0000_0007);
    rdchk(OFS_CTRL_A, 32'h0000_0007);
    apb(1'b1, OFS_PERIOD, 32'h0000_0005);
    chk(serr, 1'b1);
    rdchk(8'h1C, 32'h0000_0000);
  endtask
  task automatic t_period();
    logic [2:0] per[4] = '{3'h1, 3'h3, 3'h7, 3'h0};
    for (int i = 0; i < 4; i++) begin
      start({1'b0, CLK_SYS, 1'b1, per[i]}, 8'h00);
      gap(1'b1, (per[i] == 3'h0) ? 1024 : per[i] * 128);
    end
    setcmp(16'h00C8);
    gap(1'b0, 1024);
    start({1'b0, CLK_SYS, 1'b1, 3'h0}, 8'h01);
    gap(1'b0, 200);
  endtask
  task automatic t_clksel();
    logic [2:0] sel[6] = '{CLK_SYS_4, CLK_SYS, CLK_HI_16, CLK_HI_64, CLK_LOW_A, CLK_LOW_B};
    int         exp[6] = '{32, 8, 512, 2048, 128, 128};
    setcmp(16'h0008);
    for (int i = 0; i < 6; i++) begin
      start({1'b0, sel[i], 1'b1, 3'h0}, 8'h01);
      gap(1'b0, exp[i]);
    end
  endtask
  // Eleven toggles from low: six rising and five falling edges
  task automatic t_ext();
    logic [15:0] v;
    for (int i = 0; i < 2; i++) begin
      start({1'b0, (i == 0) ? CLK_EXT_RISE : CLK_EXT_FALL, 1'b1, 3'h0}, 8'h00);
      repeat (11) begin
        repeat (4) @(posedge clk);
        extClkPin <= ~extClkPin;
      end
      repeat (8) @(posedge clk);
      rd_pair(OFS_CNT_HI, v);
      chk(v, (i == 0) ? 16'h0006 : 16'h0005);
      extClkPin <= 1'b0;
    end
  endtask
  task automatic t_hold();
    logic [15:0] a, b;
    start({1'b0, CLK_SYS, 1'b1, 3'h0}, 8'h00);
    repeat (300) @(posedge clk);
    apb(1'b1, OFS_CTRL_A, {24'h00_0000, 1'b1, CLK_SYS, 1'b1, 3'h0});
    rd_pair(OFS_CNT_HI, a);
    repeat (20) @(posedge clk);
    rd_pair(OFS_CNT_HI, b);
    chk(b, a);
    apb(1'b1, OFS_CTRL_A, {24'h00_0000, 1'b0, CLK_SYS, 1'b1, 3'h0});
    rd_pair(OFS_CNT_HI, b);
    chk(b > a && b - a < 16'h0028, 1'b1);
    apb(1'b1, OFS_CTRL_A, {24'h00_0000, 1'b0, CLK_SYS, 1'b0, 3'h0});
    rd_pair(OFS_CNT_HI, a);
    repeat (20) @(posedge clk);
    rd_pair(OFS_CNT_HI, b);
    chk(b, a);
    apb(1'b1, OFS_CTRL_A, {24'h00_0000, 1'b0, CLK_SYS, 1'b1, 3'h0});
    rd_pair(OFS_CNT_HI, b);
    chk(b < 16'h0010 && a > 16'h0100, 1'b1);
  endtask
  task automatic t_pin();
    logic [1:0] fn[4] = '{FN_0, FN_1, FN_2, FN_3};
    logic       oc[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic       lv[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    int         n;
    setcmp(16'h0032);
    for (int i = 0; i < 4; i++) begin
      start({1'b0, CLK_SYS, 1'b1, 3'h0}, {MODE_CMP, fn[i], oc[i], 3'h1});
      repeat (2) @(negedge clk);
      chk(timerOutPin, oc[i]);
      pulse(1'b0, 100, n);
      repeat (2) @(negedge clk);
      chk(timerOutPin, lv[i]);
    end
  endtask
  task automatic t_capture();
    logic [15:0] v;
    int          n;
    start({1'b0, CLK_SYS, 1'b1, 3'h0}, {MODE_CAP, FN_0, 4'h0});
    repeat (40) @(posedge clk);
    capturePin <= 1'b1;
    pulse(1'b0, 20, n);
    chk(n < 20, 1'b1);
    rd_pair(OFS_CMP_HI, v);
    chk(v > 16'h0020 && v < 16'h0050, 1'b1);
    // Fall while rising-only, then a rise with capture off: no request
    capturePin <= 1'b0;
    apb(1'b1, OFS_CTRL_B, {24'h00_0000, MODE_CAP, FN_3, 4'h0});
    capturePin <= 1'b1;
    pulse(1'b0, 30, n);
    chk(n, 30);
  endtask
  // PWM at duty 32 of 128 clocks, then inverted, then timer mode parks low
  task automatic t_pwm();
    int n;
    setcmp(16'h0020);
    start({1'b0, CLK_SYS, 1'b1, 3'h1}, {MODE_PWM, FN_2, 1'b1, 3'h0});
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, OFS_CTRL_B, {24'h00_0000, MODE_PWM, FN_2, 1'b1, p[0], 2'h0});
      repeat (4) @(negedge clk);
      n = 0;
      repeat (128) begin
        @(negedge clk);
        n += timerOutPin;
      end
      chk(n, p[0] ? 96 : 32);
    end
    apb(1'b1, OFS_CTRL_B, {24'h00_0000, MODE_TMR, FN_2, 4'h0});
    repeat (2) @(negedge clk);
    chk(timerOutPin, 1'b0);
  endtask

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    extClkPin = 1'b0;
    capturePin = 1'b0;
    highClkSrc = 1'b0;
    lowClkSrc = 1'b0;
    tk = 0;
    num_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_period();
    t_clksel();
    t_ext();
    t_hold();
    t_pin();
    t_pwm();
    t_capture();
    wrap_up();
  end
endmodule
